// ---- include/mbst_map.svh ----
// Constants of the memory boundary-scan test access port.
// Assumes inclusion by bare name; holds definitions only.
`ifndef MBST_MAP_SVH
`define MBST_MAP_SVH

// Instruction register
`define MBST_IR_W           8
`define MBST_IR_EXTEST      8'h00
`define MBST_IR_IDCODE      8'h21
`define MBST_IR_SAMPLE      8'h05
`define MBST_IR_CLAMP       8'h07
`define MBST_IR_HIGHZ       8'h03
`define MBST_IR_BYPASS      8'hff
`define MBST_IR_CAPTURE     8'h01

// Data registers
`define MBST_BSR_LEN        113
`define MBST_ID_W           32
`define MBST_BYPASS_CAPTURE 1'b0

// Identification word layout
`define MBST_ID_PRESENT     1'b1
`define MBST_ID_VENDOR_LSB  1
`define MBST_ID_DEVICE_LSB  12
`define MBST_ID_WIDTH_LSB   28
`define MBST_ID_REV_LSB     30
`define MBST_ID_WIDTH_X9    2'h0
`define MBST_ID_WIDTH_X18   2'h1

// Cell numbers, counted from 1 at the end nearest the serial output
`define MBST_CELL_WDCLK     1
`define MBST_CELL_WDCLK_N   2
`define MBST_CELL_CHIP_SEL  3
`define MBST_CELL_REFRESH   4
`define MBST_CELL_WRITE_EN  5
`define MBST_CELL_IMP_REF   28
`define MBST_CELLS_PER_BALL 2
`define MBST_X18_LO_FIRST   10
`define MBST_X18_HI_FIRST   85
`define MBST_X18_HI_LAST    104

`endif

// ---- include/mbst_pkg.sv ----
// Types of the memory boundary-scan test access port.
// Assumes mbst_map.svh on the include path.
`include "mbst_map.svh"

package mbst_pkg;

   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
      ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
   } mbst_tap_t;

   typedef enum logic [1:0] {SEL_BYP, SEL_ID, SEL_BSR} mbst_dsel_t;

   typedef logic [`MBST_BSR_LEN-1:0] mbst_cells_t;
   typedef logic [`MBST_IR_W-1:0]    mbst_ir_t;

endpackage : mbst_pkg

// ---- include/mbst_bsr_if.sv ----
// Carrier between the port controller and the boundary-scan cells.
// The cell end runs on the test clock; the controller end takes upd on the system clock.
`timescale 1ns/1ps
`default_nettype none

interface mbst_bsr_if;
   import mbst_pkg::*;
   logic        capture;
   logic        shift;
   logic        update;
   logic        sdi;
   logic        x18;
   mbst_cells_t ring;
   logic        sdo;
   mbst_cells_t upd;

   modport tap   (output capture, shift, update, sdi, x18, ring, input sdo, upd);
   modport cells (input capture, shift, update, sdi, x18, ring, output sdo, upd);
endinterface : mbst_bsr_if

`default_nettype wire

// ---- design/mbst_bsr_cells.sv ----
// Boundary-scan register: capture, shift and update stages.
// Clocked by the test clock; controls come from the port controller.
`timescale 1ns/1ps
`default_nettype none
`include "mbst_map.svh"

module mbst_bsr_cells (
   // Test clock
   input  wire logic tck_i,
   // Controller side
   mbst_bsr_if.cells bif
);
   import mbst_pkg::*;

   typedef struct packed {
      mbst_cells_t sh;
      mbst_cells_t upd;
   } mbst_bsr_st_t;

   mbst_bsr_st_t b_r;
   mbst_bsr_st_t b_nxt;
   mbst_cells_t  x9_unused;

   // Cell n sits at vector bit n-1; bit 0 leaves first
   function automatic logic x9_idle(input int n);
      x9_idle = (n >= `MBST_X18_LO_FIRST && n < `MBST_CELL_IMP_REF) ||
                (n >= `MBST_X18_HI_FIRST && n <= `MBST_X18_HI_LAST);
   endfunction : x9_idle

   for (genvar g = 0; g < `MBST_BSR_LEN; g++) begin : g_mask
      assign x9_unused[g] = x9_idle(g + 1);
   end

   always_comb begin
      b_nxt = b_r;
      if (bif.capture) begin
         // Unused x9 positions capture zero but still shift
         b_nxt.sh = bif.x18 ? bif.ring : (bif.ring & ~x9_unused);
      end else if (bif.shift) begin
         b_nxt.sh = {bif.sdi, b_r.sh[`MBST_BSR_LEN-1:1]};
      end
      if (bif.update) begin
         b_nxt.upd = b_r.sh;
      end
   end

   always_ff @(posedge tck_i) begin
      b_r <= b_nxt;
   end

   assign bif.sdo = b_r.sh[0];
   assign bif.upd = b_r.upd;

endmodule : mbst_bsr_cells

`default_nettype wire

// ---- design/mbst_tap_top.sv ----
// Boundary-scan test access port of a separate-I/O memory device.
// Assumes a free-running system clock and a test clock from an outside controller.
`timescale 1ns/1ps
`default_nettype none
`include "mbst_map.svh"

// Notes on behaviour
// - EXTEST code 00 selects and captures the boundary chain.
// - IDCODE code 21 loads and selects the identification word.
// - SAMPLE/PRELOAD code 05 captures the ring and selects the boundary chain.
// - CLAMP code 07 selects bypass and drives balls from held chain values.
// - HIGHZ code 03 selects bypass and floats every ball output.
// - BYPASS code ff selects bypass, leaving memory untouched.
// - Identification bit 0 always reads one.
// - Identification bits 11 to 1 hold the fixed vendor code.
// - Identification bits 27 to 12 hold the device code.
// - Bits 31 to 28 hold die revision then width code.
// - Chain is 113 cells, top end at serial input.
// - Reset and test-logic-reset load the identification instruction.
module mbst_tap_top #(
   parameter logic [1:0]  DIE_REV     = 2'h0,     // Arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h0000, // Arbitrary value
   parameter logic [10:0] VENDOR_CODE = 11'h000   // Arbitrary value
) (
   // System clock domain
   input  wire logic                 clk_i,
   input  wire logic                 srst_i,
   input  wire logic                 ce_i,
   // Test port
   input  wire logic                 tck_i,
   input  wire logic                 tms_i,
   input  wire logic                 tdi_i,
   output logic                      tdo_o,
   output logic                      tdo_oe_n_o,
   // Configuration strap
   input  wire logic                 cfg_x18_i,
   // Ball ring
   input  wire mbst_pkg::mbst_cells_t ring_i,
   input  wire mbst_pkg::mbst_cells_t core_out_i,
   input  wire mbst_pkg::mbst_cells_t core_oe_n_i,
   output mbst_pkg::mbst_cells_t     pad_out_o,
   output mbst_pkg::mbst_cells_t     pad_oe_n_o
);
   import mbst_pkg::*;

   localparam int SYN_W = `MBST_BSR_LEN + 1;

   typedef struct packed {
      logic             rst1;
      logic             rst2;
      logic             rst3;
      logic [SYN_W-1:0] in1;
      logic [SYN_W-1:0] in2;
      logic [SYN_W-1:0] in3;
      logic [SYN_W-1:0] in_f;
      mbst_tap_t        state;
      mbst_ir_t         ir_sh;
      mbst_ir_t         ir;
      logic             bypass;
      logic [`MBST_ID_W-1:0] id_sh;
      logic             drv;
      logic             hiz;
      logic             tgl;
   } mbst_tck_st_t;

   typedef struct packed {
      logic tdo;
      logic tdo_oe_n;
   } mbst_neg_st_t;

   typedef struct packed {
      logic [1:0]  m1;
      logic [1:0]  m2;
      logic [1:0]  m3;
      logic [1:0]  mode;
      logic        tg1;
      logic        tg2;
      logic        tg3;
      logic        tseen;
      mbst_cells_t upd;
      mbst_cells_t pad_out;
      mbst_cells_t pad_oe_n;
   } mbst_clk_st_t;

   mbst_tck_st_t t_r;
   mbst_tck_st_t t_nxt;
   mbst_neg_st_t n_r;
   mbst_neg_st_t n_nxt;
   mbst_clk_st_t c_r;
   mbst_clk_st_t c_nxt;
   mbst_dsel_t   sel;
   logic         x18;

   mbst_bsr_if bif ();

   function automatic mbst_tap_t tap_next(input mbst_tap_t s, input logic tms);
      case (s)
         ST_TLR:    tap_next = tms ? ST_TLR    : ST_RTI;
         ST_RTI:    tap_next = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  tap_next = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PA_DR;
         ST_PA_DR:  tap_next = tms ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: tap_next = tms ? ST_TLR    : ST_CAP_IR;
         ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  tap_next = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PA_IR;
         ST_PA_IR:  tap_next = tms ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
         default:   tap_next = ST_TLR;
      endcase
   endfunction : tap_next

   // Reserved codes fall back to bypass
   function automatic mbst_dsel_t dr_select(input mbst_ir_t ir);
      case (ir)
         `MBST_IR_EXTEST: dr_select = SEL_BSR;
         `MBST_IR_SAMPLE: dr_select = SEL_BSR;
         `MBST_IR_IDCODE: dr_select = SEL_ID;
         default:         dr_select = SEL_BYP;
      endcase
   endfunction : dr_select

   assign sel = dr_select(t_r.ir);
   assign x18 = t_r.in_f[SYN_W-1];

   // Test clock domain: controller, instruction and small data registers
   always_comb begin
      t_nxt      = t_r;
      t_nxt.rst1 = srst_i;
      t_nxt.rst2 = t_r.rst1;
      t_nxt.rst3 = t_r.rst2;
      t_nxt.in1  = {cfg_x18_i, ring_i};
      t_nxt.in2  = t_r.in1;
      t_nxt.in3  = t_r.in2;
      // A pin change counts once the second and third stages agree
      t_nxt.in_f = (t_r.in2 & t_r.in3) | (t_r.in_f & (t_r.in2 ^ t_r.in3));
      t_nxt.state = tap_next(t_r.state, tms_i);
      case (t_r.state)
         ST_TLR: begin
            t_nxt.ir = `MBST_IR_IDCODE;
         end
         ST_CAP_IR: begin
            t_nxt.ir_sh = `MBST_IR_CAPTURE;
         end
         ST_SH_IR: begin
            t_nxt.ir_sh = {tdi_i, t_r.ir_sh[`MBST_IR_W-1:1]};
         end
         ST_UPD_IR: begin
            t_nxt.ir = t_r.ir_sh;
         end
         ST_CAP_DR: begin
            t_nxt.bypass = `MBST_BYPASS_CAPTURE;
            if (sel == SEL_ID) begin
               t_nxt.id_sh = {DIE_REV,
                              x18 ? `MBST_ID_WIDTH_X18 : `MBST_ID_WIDTH_X9,
                              DEVICE_CODE,
                              VENDOR_CODE,
                              `MBST_ID_PRESENT};
            end
         end
         ST_SH_DR: begin
            t_nxt.bypass = tdi_i;
            t_nxt.id_sh  = {tdi_i, t_r.id_sh[`MBST_ID_W-1:1]};
         end
         ST_UPD_DR: begin
            if (sel == SEL_BSR) begin
               t_nxt.tgl = ~t_r.tgl;
            end
         end
         default: begin
         end
      endcase
      if (t_r.rst2 && t_r.rst3) begin
         t_nxt.state = ST_TLR;
         t_nxt.ir    = `MBST_IR_IDCODE;
         // Update toggle restarts in step with the cleared system side
         t_nxt.tgl   = 1'b0;
      end
      t_nxt.drv = (t_nxt.ir == `MBST_IR_EXTEST) || (t_nxt.ir == `MBST_IR_CLAMP);
      t_nxt.hiz = (t_nxt.ir == `MBST_IR_HIGHZ);
   end

   always_ff @(posedge tck_i) begin
      t_r <= t_nxt;
   end

   // Boundary chain controls
   assign bif.capture = (t_r.state == ST_CAP_DR) && (sel == SEL_BSR);
   assign bif.shift   = (t_r.state == ST_SH_DR) && (sel == SEL_BSR);
   assign bif.update  = (t_r.state == ST_UPD_DR) && (sel == SEL_BSR);
   assign bif.sdi     = tdi_i;
   assign bif.x18     = x18;
   assign bif.ring    = t_r.in_f[`MBST_BSR_LEN-1:0];

   mbst_bsr_cells u_cells (
      .tck_i (tck_i),
      .bif   (bif.cells)
   );

   // Serial output changes on the falling test-clock edge
   always_comb begin
      n_nxt          = n_r;
      n_nxt.tdo_oe_n = !((t_r.state == ST_SH_IR) || (t_r.state == ST_SH_DR));
      if (t_r.state == ST_SH_IR) begin
         n_nxt.tdo = t_r.ir_sh[0];
      end else if (t_r.state == ST_SH_DR) begin
         case (sel)
            SEL_ID:  n_nxt.tdo = t_r.id_sh[0];
            SEL_BSR: n_nxt.tdo = bif.sdo;
            default: n_nxt.tdo = t_r.bypass;
         endcase
      end
   end

   always_ff @(negedge tck_i) begin
      n_r <= n_nxt;
   end

   assign tdo_o      = n_r.tdo;
   assign tdo_oe_n_o = n_r.tdo_oe_n;

   // System clock domain: mode and held chain values steer the balls
   always_comb begin
      c_nxt     = c_r;
      c_nxt.m1  = {t_r.drv, t_r.hiz};
      c_nxt.m2  = c_r.m1;
      c_nxt.m3  = c_r.m2;
      if (c_r.m2 == c_r.m3) begin
         c_nxt.mode = c_r.m3;
      end
      c_nxt.tg1 = t_r.tgl;
      c_nxt.tg2 = c_r.tg1;
      c_nxt.tg3 = c_r.tg2;
      // Held chain values are stable long before the toggle arrives
      if ((c_r.tg2 == c_r.tg3) && (c_r.tg3 != c_r.tseen)) begin
         c_nxt.tseen = c_r.tg3;
         c_nxt.upd   = bif.upd;
      end
      if (c_r.mode[0]) begin
         c_nxt.pad_out  = core_out_i;
         c_nxt.pad_oe_n = '1;
      end else if (c_r.mode[1]) begin
         c_nxt.pad_out  = c_r.upd;
         c_nxt.pad_oe_n = '0;
      end else begin
         c_nxt.pad_out  = core_out_i;
         c_nxt.pad_oe_n = core_oe_n_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         c_r          <= '0;
         c_r.pad_oe_n <= '1;
      end else if (ce_i) begin
         c_r <= c_nxt;
      end
   end

   assign pad_out_o  = c_r.pad_out;
   assign pad_oe_n_o = c_r.pad_oe_n;

endmodule : mbst_tap_top

`default_nettype wire

// ---- tb/mbst_tap_top_asserts.sv ----
// Checker of the boundary-scan port pins and the ball ring outputs.
// Assumes binding to mbst_tap_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module mbst_tap_top_asserts
   import mbst_pkg::*;
(
   // System domain
   input wire logic                  clk_i,
   input wire logic                  srst_i,
   input wire mbst_pkg::mbst_cells_t core_out_i,
   input wire mbst_pkg::mbst_cells_t core_oe_n_i,
   input wire mbst_pkg::mbst_cells_t pad_out_o,
   input wire mbst_pkg::mbst_cells_t pad_oe_n_o,
   // Test port
   input wire logic                  tck_i,
   input wire logic                  tms_i,
   input wire logic                  tdo_o,
   input wire logic                  tdo_oe_n_o
);
   logic tdo_rise_r;
   logic oe_rise_r;

   // Output state just before each rise, to prove the rise never moves it
   always_ff @(posedge tck_i) begin
      tdo_rise_r <= tdo_o;
      oe_rise_r  <= tdo_oe_n_o;
   end

   sequence s_shift_exit;
      !tdo_oe_n_o ##0 tms_i;
   endsequence

   property p_exit;
      @(negedge tck_i) disable iff (srst_i) s_shift_exit |=> tdo_oe_n_o [*3];
   endproperty

   AST_FALL_ONLY: assert property (@(negedge tck_i) disable iff (srst_i)
      !tdo_oe_n_o |-> (tdo_o == tdo_rise_r && !oe_rise_r))
      else $error("serial output moved on a rising test clock");
   AST_EXIT_HOLD: assert property (p_exit)
      else $error("shift left but output enable back too soon");
   AST_ENTRY: assert property (@(negedge tck_i) disable iff (srst_i)
      $fell(tdo_oe_n_o) |-> !$past(tms_i))
      else $error("shift entered with mode select high");
   AST_STAY: assert property (@(negedge tck_i) disable iff (srst_i)
      (!tdo_oe_n_o && !tms_i) |=> !tdo_oe_n_o)
      else $error("shift left with mode select low");
   AST_STABLE_OUT: assert property (@(negedge tck_i) disable iff (srst_i)
      (tdo_oe_n_o && !$past(tdo_oe_n_o)) |-> $stable(tdo_o))
      else $error("serial output changed on leaving shift");
   AST_HIGHZ_DATA: assert property (@(posedge clk_i) disable iff (srst_i)
      (pad_oe_n_o == '1 && !$past(srst_i)) |-> pad_out_o == $past(core_out_i))
      else $error("floated balls lost core data");
   AST_PASS_DATA: assert property (@(posedge clk_i) disable iff (srst_i)
      (pad_oe_n_o == $past(core_oe_n_i) && pad_oe_n_o != '0 && !$past(srst_i))
      |-> pad_out_o == $past(core_out_i))
      else $error("passthrough data differs from core");
   AST_MODE_SHAPE: assert property (@(posedge clk_i) disable iff (srst_i)
      !$past(srst_i) |->
      (pad_oe_n_o == '0 || pad_oe_n_o == '1 || pad_oe_n_o == $past(core_oe_n_i)))
      else $error("ball enables match no mode");
endmodule : mbst_tap_top_asserts

bind mbst_tap_top mbst_tap_top_asserts u_mbst_tap_top_asserts (
   .clk_i(clk_i), .srst_i(srst_i), .core_out_i(core_out_i), .core_oe_n_i(core_oe_n_i),
   .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .tck_i(tck_i), .tms_i(tms_i),
   .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o));

`default_nettype wire

// ---- tb/mbst_jtag_ctrl.sv ----
// Model of the outside test controller; the test clock runs only in frames.
// Assumes the port samples on test-clock rise and drives its output on fall.
`timescale 1ns/1ps
`default_nettype none

module mbst_jtag_ctrl (
   // Test port
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   input  wire logic tdo_i
);
   logic [127:0] seen;

   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end

   // One 64 ns test clock period; output taken at the rise
   task automatic step(input logic m, input logic d);
      tms_o = m;
      tdi_o = d;
      #32 tck_o = 1'b1;
      seen = {tdo_i, seen[127:1]};
      #32 tck_o = 1'b0;
   endtask : step

   // Data line toggles while nothing is shifted
   task automatic go(input int n, input logic m);
      repeat (n) step(m, ~tdi_o);
   endtask : go

   // From idle: one instruction or data scan of n bits, back to idle
   task automatic scan(input logic ir, input int n, input logic [127:0] din,
                       output logic [127:0] dout);
      step(1'b1, 1'b0);
      if (ir) step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
      for (int i = 0; i < n; i++) step(i == n - 1, din[i]);
      dout = seen >> (128 - n);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask : scan
endmodule : mbst_jtag_ctrl

`default_nettype wire

// ---- tb/tb_mbst_tap_top.sv ----
// Bench of the boundary-scan port: paths, ball modes, widths and resets.
// Assumes the controller model drives the test port from its own clock.
`timescale 1ns/1ps
`default_nettype none
`include "mbst_map.svh"

module tb_mbst_tap_top;
   import mbst_pkg::*;
   typedef struct packed {mbst_ir_t code; logic [1:0] sel; logic [1:0] mode;} mbst_row_t;
   localparam logic [1:0] REV = 2'h2;      // Arbitrary value
   localparam logic [15:0] DEV = 16'h5a3c; // Arbitrary value
   localparam logic [10:0] VEN = 11'h2b6;  // Arbitrary value
   localparam logic [127:0] PAT = 128'h35c9_e0a4_72db_1f86_9b3e_c450_a7d1_682f;
   localparam logic [127:0] RB = 128'h6d2b_79f1_0e4c_a357_b816_d9e2_4f03_c5a1;
   // Path: 0 bypass, 1 ident, 2 chain; balls: 0 core, 1 chain, 2 float
   localparam mbst_row_t ROWS [6] = '{
      '{`MBST_IR_SAMPLE, 2'h2, 2'h0},
      '{`MBST_IR_EXTEST, 2'h2, 2'h1},
      '{`MBST_IR_CLAMP, 2'h0, 2'h1},
      '{`MBST_IR_HIGHZ, 2'h0, 2'h2},
      '{`MBST_IR_BYPASS, 2'h0, 2'h0},
      '{`MBST_IR_IDCODE, 2'h1, 2'h0}
   };
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic cfg_x18_i = 1'b1;
   wire logic tck, tms, tdi;
   logic tdo_o, tdo_oe_n_o;
   mbst_cells_t ring = RB[112:0];
   mbst_cells_t cout = RB[127:15];
   mbst_cells_t coe = ~RB[120:8];
   mbst_cells_t pad_out_o, pad_oe_n_o, e_oe, e_out, cap9;
   logic [127:0] so;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;

   mbst_tap_top #(.DIE_REV(REV), .DEVICE_CODE(DEV), .VENDOR_CODE(VEN)) u_mbst_tap_top (
      .clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .cfg_x18_i(cfg_x18_i), .ring_i(ring),
      .core_out_i(cout), .core_oe_n_i(coe), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o));
   mbst_jtag_ctrl u_mbst_jtag_ctrl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_o));

   always #50 clk_i = ~clk_i;

   function automatic logic [31:0] idv(input logic w);
      return {REV, 1'b0, w, DEV, VEN, 1'b1};
   endfunction : idv

   // What a 128-bit data scan of PAT returns on each path
   function automatic logic [127:0] expv(input logic [1:0] sel, input logic [31:0] id,
                                         input mbst_cells_t cap);
      if (sel == 2'h0) return {PAT[126:0], `MBST_BYPASS_CAPTURE};
      if (sel == 2'h1) return {PAT[95:0], id};
      return {PAT[14:0], cap};
   endfunction : expv

   task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run

   task automatic hold_reset(input logic m);
      fork
         repeat (8) @(posedge clk_i);
         u_mbst_jtag_ctrl.go(6, m);
      join
      srst_i <= 1'b0;
      u_mbst_jtag_ctrl.go(5, m);
      u_mbst_jtag_ctrl.go(1, 1'b0);
   endtask : hold_reset

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         complete_run();
      end
   end

   initial begin
      cap9 = ring;
      for (int c = 10; c <= 104; c++) if (c < 28 || c > 84) cap9[c-1] = 1'b0;
      hold_reset(1'b1);
      u_mbst_jtag_ctrl.scan(1'b0, 128, PAT, so);
      chk("ident after reset", expv(2'h1, idv(1'b1), ring), so);
      for (int r = 0; r < 6; r++) begin
         u_mbst_jtag_ctrl.scan(1'b1, 8, {120'h0, ROWS[r].code}, so);
         chk("instr capture", 128'h01, so);
         u_mbst_jtag_ctrl.scan(1'b0, 128, PAT, so);
         chk("data path", expv(ROWS[r].sel, idv(1'b1), ring), so);
         e_oe = ROWS[r].mode == 2'h1 ? '0 : ROWS[r].mode == 2'h2 ? '1 : coe;
         e_out = ROWS[r].mode == 2'h1 ? PAT[127:15] : cout;
         repeat (10) @(posedge clk_i);
         @(negedge clk_i);
         chk("ball enable", 128'(e_oe), 128'(pad_oe_n_o));
         chk("ball data", 128'(e_out), 128'(pad_out_o));
      end
      @(posedge clk_i) cfg_x18_i <= 1'b0;
      u_mbst_jtag_ctrl.scan(1'b1, 8, {120'h0, `MBST_IR_SAMPLE}, so);
      u_mbst_jtag_ctrl.scan(1'b0, 128, PAT, so);
      chk("narrow chain", expv(2'h2, 32'h0, cap9), so);
      @(posedge clk_i) srst_i <= 1'b1;
      hold_reset(1'b0);
      u_mbst_jtag_ctrl.scan(1'b0, 128, PAT, so);
      chk("ident after reset", expv(2'h1, idv(1'b0), ring), so);
      u_mbst_jtag_ctrl.scan(1'b1, 8, {120'h0, `MBST_IR_BYPASS}, so);
      u_mbst_jtag_ctrl.go(5, 1'b1);
      u_mbst_jtag_ctrl.go(1, 1'b0);
      u_mbst_jtag_ctrl.scan(1'b0, 128, PAT, so);
      chk("ident after mode reset", expv(2'h1, idv(1'b0), ring), so);
      complete_run();
   end
endmodule : tb_mbst_tap_top

`default_nettype wire
